/* afc_map.svh */
// register indices, field positions, masks and reset values of the analog front end control
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH

// =====================================================================
// register indices (byte address = index * 4)
`define AFC_IDX_REGULATOR  8'h8A
`define AFC_IDX_PUMP       8'h8B
`define AFC_IDX_AMP2_DIV   8'hB9
`define AFC_IDX_AMP2_MODE  8'hBA
`define AFC_IDX_AMP1_DIV   8'hBB
`define AFC_IDX_AMP1_MODE  8'hBC

// =====================================================================
// field positions
`define AFC_REG_HIGH_BIT   0
`define AFC_REG_LOW_BIT    1
`define AFC_PUMP_MSB       1
`define AFC_PUMP_LSB       0
`define AFC_EN_BIT         0
`define AFC_G1_MSB         2
`define AFC_G1_LSB         1
`define AFC_G2_MSB         7
`define AFC_G2_LSB         4

// =====================================================================
// implemented bits, reset values, divider constants
`define AFC_MASK_REGULATOR 8'h03
`define AFC_MASK_PUMP      8'h03
`define AFC_MASK_MODE      8'hF7
`define AFC_MASK_DIV       8'hFF
`define AFC_RST_VAL        8'h00
`define AFC_SPAN_LAST      8'hFF
`define AFC_DIV_SPAN       9'h100
`define AFC_POST_DIV       8
`define AFC_G1_BASE_SHIFT  3'h4

`endif

/* afc_pkg.sv */
// shared types of the analog front end control
package afc_pkg;

  typedef logic [7:0] afc_byte_t;

  typedef enum logic [1:0] {
    AFC_PUMP_FASTEST,
    AFC_PUMP_FASTER,
    AFC_PUMP_SLOWER,
    AFC_PUMP_SLOWEST
  } afc_pump_speed_e;

endpackage

/* afc_gain_decode.sv */
// decodes one amplifier mode byte into stage gains and their product
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.svh"

module afc_gain_decode
  import afc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire afc_byte_t   mode,
  output logic [7:0]       stage1_gain,
  output logic [15:0]      stage2_gain,
  output logic [23:0]      total_gain
);

  // =====================================================================
  // stage-two gain table, unsigned fixed point with 12 fraction bits
  localparam logic [15:0] G2_LUT [16] = '{
    16'h1536, 16'h1618, 16'h1706, 16'h1800, 16'h1907, 16'h1A1B, 16'h1B3E, 16'h1C72,
    16'h1DB7, 16'h1F0F, 16'h207C, 16'h2200, 16'h239D, 16'h2555, 16'h272C, 16'h2925
  };
  localparam logic [7:0]  G1_AT_RESET    = 8'h10;
  localparam logic [23:0] TOTAL_AT_RESET = 24'h015360;

  logic [3:0] g2_code;
  logic [2:0] g1_shift;

  assign g2_code  = mode[`AFC_G2_MSB:`AFC_G2_LSB];
  assign g1_shift = `AFC_G1_BASE_SHIFT + {1'b0, mode[`AFC_G1_MSB:`AFC_G1_LSB]};

  // stage one is a power of two, so the product is a shift of the table value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_gain <= G1_AT_RESET;
      stage2_gain <= G2_LUT[0];
      total_gain  <= TOTAL_AT_RESET;
    end else begin
      stage1_gain <= 8'h01 << g1_shift;
      stage2_gain <= G2_LUT[g2_code];
      total_gain  <= {8'h00, G2_LUT[g2_code]} << g1_shift;
    end
  end

endmodule
`default_nettype wire

/* afc_work_clkdiv.sv */
// amplifier working clock divider: (256 - divisor) oscillator ticks, then a further 8
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.svh"

module afc_work_clkdiv
  import afc_pkg::*;
#(
  parameter int POST_DIV = `AFC_POST_DIV
) (
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      enable,
  input  wire logic      hosc_tick,
  input  wire afc_byte_t divisor,
  output logic           work_clk,
  output logic           work_tick
);

  localparam int PW = $clog2(POST_DIV);

  afc_byte_t       span_q;
  logic            pre_q;
  logic [PW-1:0]   post_q;
  logic [PW-1:0]   post_inc;

  assign post_inc = post_q + PW'(1);

  // =====================================================================
  // first stage: count oscillator ticks from divisor up to 255
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_q <= `AFC_RST_VAL;
      pre_q  <= 1'b0;
    end else if (!enable) begin
      span_q <= divisor;
      pre_q  <= 1'b0;
    end else if (hosc_tick) begin
      if (span_q == `AFC_SPAN_LAST) begin
        span_q <= divisor;
        pre_q  <= 1'b1;
      end else begin
        span_q <= span_q + 8'h01;
        pre_q  <= 1'b0;
      end
    end else begin
      pre_q <= 1'b0;
    end
  end

  // =====================================================================
  // second stage: fixed post divider, square wave out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q    <= '0;
      work_clk  <= 1'b0;
      work_tick <= 1'b0;
    end else if (!enable) begin
      post_q    <= '0;
      work_clk  <= 1'b0;
      work_tick <= 1'b0;
    end else if (pre_q) begin
      post_q    <= post_inc;
      work_clk  <= post_inc[PW-1];
      work_tick <= (post_inc == '0);
    end else begin
      work_tick <= 1'b0;
    end
  end

  // =====================================================================
  // helper: oscillator ticks seen between two first-stage pulses
  logic [8:0] seen_q;
  logic       clean_q;
  afc_byte_t  div_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q     <= 9'h000;
      clean_q    <= 1'b0;
      div_prev_q <= `AFC_RST_VAL;
    end else begin
      div_prev_q <= divisor;
      clean_q    <= enable & (pre_q | clean_q) & (divisor == div_prev_q);
      if (!enable || pre_q) begin
        seen_q <= {8'h00, hosc_tick & enable};
      end else begin
        seen_q <= seen_q + {8'h00, hosc_tick};
      end
    end
  end

  AST_DIV_SPAN: assert property (
    @(posedge pclk) disable iff (!presetn)
    pre_q && clean_q && divisor == div_prev_q |-> seen_q == (`AFC_DIV_SPAN - {1'b0, divisor}))
    else $error("first divider stage span does not match divisor");

  AST_DIV_GATED: assert property (
    @(posedge pclk) disable iff (!presetn)
    !enable |=> !work_clk && !work_tick)
    else $error("working clock active while channel disabled");

  AST_POST_STEP: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(work_clk) && $past(enable) && enable |-> $past(pre_q))
    else $error("working clock moved without a first-stage pulse");

endmodule
`default_nettype wire

/* afc_frontend_ctrl.sv */
// analog front end control: APB register file, regulator and pump controls, two amp channels
//
// Overview of operation
// - Regulator register bit 0 switches the higher analog regulator on at 1 and off at 0.
// - Regulator register bit 1 switches the lower analog regulator on at 1 and off at 0.
// - Pump clock select 00, 01, 10, 11 picks fastest, faster, slower, slowest pump clock.
// - Amp 1 mode bit 0 enables that channel at 1 and disables it at 0.
// - Amp 1 mode bits 2:1 give stage-one gain 16, 32, 64 or 128.
// - Amp 1 mode bits 7:4 give a stage-two gain rising from about 1.33 to 2.57.
// - Amp 2 mode register uses the same enable and gain encodings as amp 1.
// - Overall amplifier gain is stage-one gain times stage-two gain.
// - Amp 1 working clock is the oscillator divided by 256 minus its divisor, then by 8.
// - Amp 2 working clock uses its own divisor with the same formula.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.svh"

module afc_frontend_ctrl
  import afc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              hosc_tick,
  output logic                   analog_reg_high_enable,
  output logic                   analog_reg_low_enable,
  output afc_pump_speed_e        pump_speed,
  output logic [1:0]             amp_channel_enable,
  output logic [1:0][7:0]        amp_stage1_gain,
  output logic [1:0][15:0]       amp_stage2_gain,
  output logic [1:0][23:0]       amp_total_gain,
  output logic [1:0]             amp_work_clk,
  output logic [1:0]             amp_work_tick
);

  localparam int NCH = 2;

  // =====================================================================
  // register state
  afc_byte_t       regulator_mode_register_q;
  afc_byte_t       pump_clock_select_q;
  afc_byte_t       amp_mode_q [NCH];
  afc_byte_t       amp_clock_divisor_q [NCH];
  afc_pump_speed_e pump_speed_q;
  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;

  // =====================================================================
  // address decode
  logic      addr_ok;
  afc_byte_t reg_idx;
  logic      hit_reg;
  logic      hit_pump;
  logic [1:0] hit_mode;
  logic [1:0] hit_div;
  logic      hit_any;
  logic      setup_phase;
  logic      wr_commit;
  afc_byte_t rd_data;

  // index sits in address bits 9:2; byte lane bits and top bits must be zero
  assign reg_idx     = paddr[9:2];
  assign addr_ok     = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign hit_reg     = addr_ok && (reg_idx == `AFC_IDX_REGULATOR);
  assign hit_pump    = addr_ok && (reg_idx == `AFC_IDX_PUMP);
  assign hit_mode[0] = addr_ok && (reg_idx == `AFC_IDX_AMP1_MODE);
  assign hit_mode[1] = addr_ok && (reg_idx == `AFC_IDX_AMP2_MODE);
  assign hit_div[0]  = addr_ok && (reg_idx == `AFC_IDX_AMP1_DIV);
  assign hit_div[1]  = addr_ok && (reg_idx == `AFC_IDX_AMP2_DIV);
  assign hit_any     = hit_reg | hit_pump | (|hit_mode) | (|hit_div);
  assign setup_phase = psel & ~penable;
  // registers are eight bits wide, so only lane 0 carries a write
  assign wr_commit   = psel & penable & pready_q & pwrite & pstrb[0];

  // =====================================================================
  // read mux; unimplemented bits come back as zero
  always_comb begin
    rd_data = `AFC_RST_VAL;
    if (hit_reg) begin
      rd_data = regulator_mode_register_q & `AFC_MASK_REGULATOR;
    end else if (hit_pump) begin
      rd_data = pump_clock_select_q & `AFC_MASK_PUMP;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (hit_mode[i]) begin
          rd_data = amp_mode_q[i] & `AFC_MASK_MODE;
        end
        if (hit_div[i]) begin
          rd_data = amp_clock_divisor_q[i];
        end
      end
    end
  end

  // =====================================================================
  // APB handshake: zero wait states, answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase & ~hit_any;
      if (setup_phase && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_data};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // =====================================================================
  // regulator and pump registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_mode_register_q <= `AFC_RST_VAL;
    end else if (wr_commit && hit_reg) begin
      regulator_mode_register_q <= pwdata[7:0] & `AFC_MASK_REGULATOR;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_clock_select_q <= `AFC_RST_VAL;
    end else if (wr_commit && hit_pump) begin
      pump_clock_select_q <= pwdata[7:0] & `AFC_MASK_PUMP;
    end
  end

  assign analog_reg_high_enable = regulator_mode_register_q[`AFC_REG_HIGH_BIT];
  assign analog_reg_low_enable  = regulator_mode_register_q[`AFC_REG_LOW_BIT];

  // pump speed held in its own flop so the port is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_speed_q <= AFC_PUMP_FASTEST;
    end else begin
      unique case (pump_clock_select_q[`AFC_PUMP_MSB:`AFC_PUMP_LSB])
        2'h0: pump_speed_q <= AFC_PUMP_FASTEST;
        2'h1: pump_speed_q <= AFC_PUMP_FASTER;
        2'h2: pump_speed_q <= AFC_PUMP_SLOWER;
        2'h3: pump_speed_q <= AFC_PUMP_SLOWEST;
      endcase
    end
  end

  assign pump_speed = pump_speed_q;

  // =====================================================================
  // amplifier channels; index 0 is amp 1, index 1 is amp 2
  // no interlock on regulator state: enabling order is left to software
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          amp_mode_q[ch] <= `AFC_RST_VAL;
        end else if (wr_commit && hit_mode[ch]) begin
          amp_mode_q[ch] <= pwdata[7:0] & `AFC_MASK_MODE;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          amp_clock_divisor_q[ch] <= `AFC_RST_VAL;
        end else if (wr_commit && hit_div[ch]) begin
          amp_clock_divisor_q[ch] <= pwdata[7:0] & `AFC_MASK_DIV;
        end
      end

      assign amp_channel_enable[ch] = amp_mode_q[ch][`AFC_EN_BIT];

      afc_gain_decode u_gain (
        .pclk        (pclk),
        .presetn     (presetn),
        .mode        (amp_mode_q[ch]),
        .stage1_gain (amp_stage1_gain[ch]),
        .stage2_gain (amp_stage2_gain[ch]),
        .total_gain  (amp_total_gain[ch])
      );

      afc_work_clkdiv #(
        .POST_DIV (`AFC_POST_DIV)
      ) u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (amp_mode_q[ch][`AFC_EN_BIT]),
        .hosc_tick (hosc_tick),
        .divisor   (amp_clock_divisor_q[ch]),
        .work_clk  (amp_work_clk[ch]),
        .work_tick (amp_work_tick[ch])
      );
    end
  endgenerate

  // =====================================================================
  // assertions
  default clocking afc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_REG_HIGH: assert property (
    wr_commit && hit_reg |=> analog_reg_high_enable == $past(pwdata[`AFC_REG_HIGH_BIT]))
    else $error("higher regulator enable did not follow the write");

  AST_REG_LOW: assert property (
    wr_commit && hit_reg |=> analog_reg_low_enable == $past(pwdata[`AFC_REG_LOW_BIT]))
    else $error("lower regulator enable did not follow the write");

  AST_PUMP_SLOWEST: assert property (
    wr_commit && hit_pump && pwdata[1:0] == 2'h3 |=> ##1 pump_speed == AFC_PUMP_SLOWEST)
    else $error("pump code 11 not decoded as slowest");

  AST_PUMP_FASTEST: assert property (
    wr_commit && hit_pump && pwdata[1:0] == 2'h0 |=> ##1 pump_speed == AFC_PUMP_FASTEST)
    else $error("pump code 00 not decoded as fastest");

  AST_AMP1_ENABLE: assert property (
    wr_commit && hit_mode[0] |=> amp_channel_enable[0] == $past(pwdata[`AFC_EN_BIT]))
    else $error("amp 1 enable did not follow the write");

  AST_G1_TOP: assert property (
    amp_mode_q[0][`AFC_G1_MSB:`AFC_G1_LSB] == 2'h3 |=> amp_stage1_gain[0] == 8'h80)
    else $error("amp 1 stage-one code 11 is not gain 128");

  AST_G2_TOP: assert property (
    amp_mode_q[0][`AFC_G2_MSB:`AFC_G2_LSB] == 4'hF |=> amp_stage2_gain[0] == 16'h2925)
    else $error("amp 1 stage-two code 1111 is not the top gain");

  AST_MIRROR: assert property (
    (amp_mode_q[1] == amp_mode_q[0]) |=>
      amp_stage1_gain[1] == amp_stage1_gain[0] && amp_stage2_gain[1] == amp_stage2_gain[0])
    else $error("amp 2 decodes differently from amp 1");

  AST_TOTAL: assert property (
    amp_total_gain[1] == 24'(amp_stage1_gain[1]) * 24'(amp_stage2_gain[1]))
    else $error("amp 2 total gain is not the product of its stages");

  AST_RESERVED_RD: assert property (
    setup_phase && !pwrite && (|hit_mode) |=>
      prdata[31:8] == 24'h00_0000 && (prdata[7:0] & ~`AFC_MASK_MODE) == 8'h00)
    else $error("reserved mode bits read as nonzero");

  AST_RESERVED_WR: assert property (
    wr_commit && hit_reg |=> (regulator_mode_register_q & ~`AFC_MASK_REGULATOR) == 8'h00)
    else $error("unimplemented regulator bits took a write");

  AST_AMP2_GATED: assert property (
    !amp_channel_enable[1] |=> !amp_work_clk[1])
    else $error("amp 2 working clock active while disabled");

  AST_UNMAPPED: assert property (
    setup_phase && !hit_any |=> pready && pslverr)
    else $error("unmapped access not answered with an error");

  AST_PUMP_FASTER: assert property (
    pump_clock_select_q[1:0] == 2'h1 |=> pump_speed == AFC_PUMP_FASTER)
    else $error("pump code 01 not decoded as faster");

  AST_PUMP_SLOWER: assert property (
    pump_clock_select_q[1:0] == 2'h2 |=> pump_speed == AFC_PUMP_SLOWER)
    else $error("pump code 10 not decoded as slower");

  AST_AMP2_ENABLE: assert property (
    wr_commit && hit_mode[1] |=> amp_channel_enable[1] == $past(pwdata[`AFC_EN_BIT]))
    else $error("amp 2 enable did not follow the write");

  AST_G1_BOTTOM: assert property (
    amp_mode_q[0][`AFC_G1_MSB:`AFC_G1_LSB] == 2'h0 |=> amp_stage1_gain[0] == 8'h10)
    else $error("amp 1 stage-one code 00 is not gain 16");

  AST_G2_BOTTOM: assert property (
    amp_mode_q[0][`AFC_G2_MSB:`AFC_G2_LSB] == 4'h0 |=> amp_stage2_gain[0] == 16'h1536)
    else $error("amp 1 stage-two code 0000 is not the bottom gain");

  AST_TOTAL_AMP1: assert property (
    amp_total_gain[0] == 24'(amp_stage1_gain[0]) * 24'(amp_stage2_gain[0]))
    else $error("amp 1 total gain is not the product of its stages");

  AST_AMP1_GATED: assert property (
    !amp_channel_enable[0] |=> !amp_work_clk[0] && !amp_work_tick[0])
    else $error("amp 1 working clock active while disabled");

  AST_REG_READ: assert property (
    setup_phase && !pwrite && hit_reg |=>
      prdata == {30'h0000_0000, analog_reg_low_enable, analog_reg_high_enable})
    else $error("regulator register read does not match its enables");

  AST_RESERVED_PUMP: assert property (
    (pump_clock_select_q & ~`AFC_MASK_PUMP) == 8'h00)
    else $error("unimplemented pump bits hold a one");

  // bus handshake shape, lane handling and amp 1 divisor hold
  AST_NO_LANE: assert property (
    psel && penable && pready && pwrite && !pstrb[0] |=> $stable(pump_clock_select_q))
    else $error("write without lane 0 strobe changed the pump register");

  AST_DIV_HOLD: assert property (
    !(wr_commit && hit_div[0]) |=> $stable(amp_clock_divisor_q[0]))
    else $error("amp 1 divisor changed without a write");

  AST_ZERO_WAIT: assert property (
    setup_phase |=> pready)
    else $error("access phase not answered at once");

  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("ready stood for more than one cycle");

  AST_RDATA_IDLE: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside the access cycle");

  COV_REG_ON:   cover property (wr_commit && hit_reg && pwdata[`AFC_REG_HIGH_BIT]);
  COV_WORK1:    cover property (amp_work_tick[0]);
  COV_BOTH_ON:  cover property (amp_channel_enable == 2'h3);
  COV_SLVERR:   cover property (pready && pslverr);
  COV_SLOWEST:  cover property (pump_speed == AFC_PUMP_SLOWEST);

endmodule
`default_nettype wire

/* afc_analog_model.sv */
// far-side model: oscillator tick source and analog supply watcher
`timescale 1ns/1ps
`default_nettype none

module afc_analog_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       reg_high_on,
  input  wire logic [1:0] amp_on,
  output logic            hosc_tick,
  output logic            order_fault
);
  // =====================================================================
  // oscillator ticks: every cycle, or every second cycle when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hosc_tick <= 1'b0;
    end else begin
      hosc_tick <= slow ? ~hosc_tick : 1'b1;
    end
  end

  // =====================================================================
  // an amplifier running without its supply would misbehave; flag it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      order_fault <= 1'b0;
    end else if (|amp_on && !reg_high_on) begin
      order_fault <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench of the analog front end control
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.svh"

module testbench
  import afc_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, slow, rerr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic [3:0]        pstrb;
  logic              pready, pslverr, hosc_tick, reg_hi, reg_lo, order_fault;
  afc_pump_speed_e   pump_speed;
  logic [1:0]        amp_channel_enable, amp_work_clk, amp_work_tick;
  logic [1:0][7:0]   amp_stage1_gain;
  logic [1:0][15:0]  amp_stage2_gain;
  logic [1:0][23:0]  amp_total_gain;
  int                num_errors, n_checks, i, j, k;

  localparam logic [15:0] S2 [16] = '{16'h1536, 16'h1618, 16'h1706, 16'h1800, 16'h1907,
    16'h1A1B, 16'h1B3E, 16'h1C72, 16'h1DB7, 16'h1F0F, 16'h207C, 16'h2200, 16'h239D,
    16'h2555, 16'h272C, 16'h2925};
  // =====================================================================
  // ordinary register rows: index, written byte, byte read back
  localparam logic [7:0] RI [10] = '{`AFC_IDX_REGULATOR, `AFC_IDX_REGULATOR, `AFC_IDX_PUMP,
    `AFC_IDX_PUMP, `AFC_IDX_AMP2_DIV, `AFC_IDX_AMP1_DIV, `AFC_IDX_AMP2_MODE,
    `AFC_IDX_AMP1_MODE, `AFC_IDX_AMP1_MODE, `AFC_IDX_REGULATOR};
  localparam logic [7:0] RW [10] = '{8'hFF, 8'h00, 8'hFF, 8'h02, 8'hA5, 8'h5A, 8'hFE, 8'h08,
    8'hF6, 8'h01};
  localparam logic [7:0] RE [10] = '{8'h03, 8'h00, 8'h03, 8'h02, 8'hA5, 8'h5A, 8'hF6, 8'h00,
    8'hF6, 8'h01};

  afc_frontend_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hosc_tick(hosc_tick),
    .analog_reg_high_enable(reg_hi), .analog_reg_low_enable(reg_lo),
    .pump_speed(pump_speed), .amp_channel_enable(amp_channel_enable),
    .amp_stage1_gain(amp_stage1_gain), .amp_stage2_gain(amp_stage2_gain),
    .amp_total_gain(amp_total_gain), .amp_work_clk(amp_work_clk),
    .amp_work_tick(amp_work_tick));

  afc_analog_model model (.pclk(pclk), .presetn(presetn), .slow(slow), .reg_high_on(reg_hi),
    .amp_on(amp_channel_enable), .hosc_tick(hosc_tick), .order_fault(order_fault));

  always #5 pclk = ~pclk;

  // =====================================================================
  // reporting
  task print_verdict;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // =====================================================================
  // bus master: request held until pready is seen at a rising edge
  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d}; pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      print_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, ra(idx), d, 4'hF);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, ra(idx), 8'h00, 4'h0);
    chk(rdat, {24'h0, e});
    chk(32'(rerr), 32'h0);
  endtask

  // =====================================================================
  // gain decode of one channel; enable kept low while gains change
  task automatic gchk(input int ch, input logic [1:0] c1, input logic [3:0] c2);
    logic [7:0] s1;
    s1 = 8'h10 << c1;
    wr(ch ? `AFC_IDX_AMP2_MODE : `AFC_IDX_AMP1_MODE, {c2, 1'b0, c1, 1'b0});
    repeat (3) @(posedge pclk);
    chk(32'(amp_stage1_gain[ch]), 32'(s1));
    chk(32'(amp_stage2_gain[ch]), 32'(S2[c2]));
    chk(32'(amp_total_gain[ch]), 32'(24'(s1) * 24'(S2[c2])));
  endtask

  // cycles between two work ticks, and cycles with the clock high
  task automatic period(input int ch, input int exp);
    int n;
    int hi;
    n = 0;
    while (amp_work_tick[ch] !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    hi = 0;
    do begin
      @(posedge pclk);
      n++;
      hi += (amp_work_clk[ch] === 1'b1);
    end while (amp_work_tick[ch] !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      num_errors++;
      print_verdict();
    end
    chk(32'(n), 32'(exp));
    chk(32'(hi), 32'(exp / 2));
  endtask

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; slow = 1'b0;
    num_errors = 0; n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({reg_hi, reg_lo, amp_channel_enable, amp_work_clk}, 32'h0);
    chk(32'(pump_speed), 32'(AFC_PUMP_FASTEST));
    chk(32'(amp_total_gain[0]), 32'h015360);
    for (i = 0; i < 6; i++) rc(i == 4 ? `AFC_IDX_PUMP : RI[i + 4], 8'h00);
    $display("test reset done");
    for (i = 0; i < 10; i++) begin
      wr(RI[i], RW[i]);
      rc(RI[i], RE[i]);
    end
    $display("test rows done");
    // settle wait kept short so the run stays brief
    repeat (100) @(posedge pclk);
    for (i = 0; i < 4; i++) begin
      wr(`AFC_IDX_REGULATOR, 8'(i));
      repeat (2) @(posedge pclk);
      chk({reg_lo, reg_hi}, 32'(i));
      wr(`AFC_IDX_PUMP, 8'(i));
      repeat (3) @(posedge pclk);
      chk(32'(pump_speed), 32'(i));
    end
    wr(`AFC_IDX_REGULATOR, 8'h01);
    apb(1'b0, ra(8'h8C), 8'h00, 4'h0);
    chk(rdat, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, ra(`AFC_IDX_PUMP) | 12'h001, 8'h01, 4'hF);
    chk(32'(rerr), 32'h1);
    apb(1'b1, ra(`AFC_IDX_PUMP), 8'h01, 4'h0);
    rc(`AFC_IDX_PUMP, 8'h03);
    $display("test controls done");
    for (i = 0; i < 2; i++)
      for (j = 0; j < 4; j++)
        for (k = 0; k < 16; k++) gchk(i, 2'(j), 4'(k));
    $display("test gains done");
    for (i = 0; i < 3; i++) begin
      k = (i == 0) ? 0 : 1;
      slow <= (i == 1);
      wr(k ? `AFC_IDX_AMP2_MODE : `AFC_IDX_AMP1_MODE, 8'h00);
      wr(k ? `AFC_IDX_AMP2_DIV : `AFC_IDX_AMP1_DIV, i == 0 ? 8'hFE : (i == 1 ? 8'h00 : 8'hD8));
      wr(k ? `AFC_IDX_AMP2_MODE : `AFC_IDX_AMP1_MODE, 8'h01);
      repeat (2) @(posedge pclk);
      chk(32'(amp_channel_enable[k]), 32'h1);
      period(k, i == 0 ? 16 : (i == 1 ? 4096 : 320));
    end
    wr(`AFC_IDX_AMP2_MODE, 8'h00);
    repeat (3) @(posedge pclk);
    j = 0;
    for (i = 0; i < 600; i++) begin
      j += (amp_work_clk[1] !== 1'b0 || amp_work_tick[1] !== 1'b0);
      @(posedge pclk);
    end
    chk(32'(j), 32'h0);
    $display("test dividers done");
    chk(32'(order_fault), 32'h0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({reg_hi, amp_channel_enable, amp_work_clk}, 32'h0);
    rc(`AFC_IDX_AMP1_DIV, 8'h00);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
